/* File: fid_device.sv */
// Flash device end: identification, error clear and table read commands
// Operation
// RQ1: Clear-error opcode zeroes three error flags
// RQ2: Error flags stick until clear-error command
// RQ3: Signature read takes three dummy bytes
// RQ4: Signature byte out msb first, falling edges
// RQ5: Signature byte repeats until select rises
// RQ6: Signature opcode also wakes, both modes
// RQ7: Standard id on 9Fh, AFh quad only
// RQ8: Maker byte then two-byte type code
// RQ9: Standard id sequence loops while selected
// RQ10: Maker/device read: two dummies, one address
// RQ11: Address bit zero picks first byte
// RQ12: Maker/device bytes alternate until deselect
// RQ13: Unique number after address and dummies
// RQ14: Sixteen unique bytes repeat while clocked
// RQ15: Low address nibble starts, bits 8:4 zero
// RQ16: Unique read framed like fast read
// RQ17: Table read after address and dummies
// RQ18: Undefined table addresses return no guarantee
// RQ19: Quad table read framed like quad read
// RQ20: No-operation only cancels pending reset-enable
// RQ21: Dummy count from read register bits
// RQ22: Signature opcode ignored while write busy
// RQ23: Deselect abandons a partial command
`timescale 1ns/100ps
module fid_device (
    input  wire logic       mclk,
    input  wire logic       resetn,
    fid_link_if.dev         link,
    input  wire logic       quad_command_mode,
    input  wire logic       write_in_progress_flag,
    input  wire logic [3:0] read_dummy_cycles,
    input  wire logic       protection_error_set,
    input  wire logic       program_error_set,
    input  wire logic       erase_error_set,
    output logic [2:0]      error_flags,
    output logic            reset_enable_pending,
    output logic            power_down_release
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [1:0] {
        PH_CMD,
        PH_ADDR,
        PH_OUT,
        PH_IGN
    } fid_phase_t;

    typedef struct packed {
        logic               cs_s1;
        logic               cs_s2;
        logic               sck_s1;
        logic               sck_s2;
        logic               sck_d;
        logic [3:0]         io_s1;
        logic [3:0]         io_s2;
        fid_phase_t         ph;
        logic [7:0]         sr;
        logic [3:0]         bits;
        logic [5:0]         clk_left;
        logic [5:0]         dum;
        logic [23:0]        addr;
        fid_pkg::fid_resp_t kind;
        logic [7:0]         idx;
        logic               ok;
        logic [3:0]         bpos;
        logic [3:0]         dout;
        logic [3:0]         doe;
        logic [2:0]         errs;
        logic               rst_en;
        logic               wake;
    } fid_dev_state_t;

    fid_dev_state_t s;
    fid_dev_state_t next_s;
    logic [7:0]     rom_byte;

    fid_resp_rom u_rom (
        .kind    (s.kind),
        .idx     (s.idx),
        .addr_ok (s.ok),
        .data    (rom_byte)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [3:0]  lanes;
        logic [3:0]  nib;
        logic [7:0]  op;
        logic [2:0]  err_set;
        logic [5:0]  aclk;
        logic [5:0]  dcnt;
        logic [23:0] na;
        logic        rise;
        logic        fall;
        lanes   = quad_command_mode ? 4'h4 : 4'h1;
        nib     = quad_command_mode ? s.io_s2 : {3'h0, s.io_s2[0]};
        op      = quad_command_mode ? {s.sr[3:0], nib} : {s.sr[6:0], nib[0]};
        err_set = {protection_error_set, program_error_set, erase_error_set};
        aclk    = quad_command_mode ? fid_pkg::ADDR_CLK_QD : fid_pkg::ADDR_CLK_SGL;
        // Zero in the register field means the default count
        dcnt    = (read_dummy_cycles == 4'h0) ? fid_pkg::DUMMY_DEF
                                              : {2'h0, read_dummy_cycles}; // [RQ21]
        na      = quad_command_mode ? {s.addr[19:0], nib} : {s.addr[22:0], nib[0]};
        rise    = s.sck_s2 & ~s.sck_d;
        fall    = ~s.sck_s2 & s.sck_d;

        next_s        = s;
        next_s.cs_s1  = link.cs_n;
        next_s.cs_s2  = s.cs_s1;
        next_s.sck_s1 = link.sck;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_d  = s.sck_s2;
        next_s.io_s1  = link.io;
        next_s.io_s2  = s.io_s1;
        next_s.wake   = 1'b0;
        // New errors win over a clear in the same cycle
        next_s.errs   = s.errs | err_set; // [RQ2]

        if (s.cs_s2)
        begin
            // Deselect drops whatever was half received
            next_s.ph   = PH_CMD; // [RQ23]
            next_s.bits = 4'h0;
            next_s.bpos = 4'h0;
            next_s.doe  = 4'h0; // [RQ5] [RQ9] [RQ12]
        end
        else if (rise && s.ph == PH_CMD)
        begin
            next_s.sr   = op;
            next_s.bits = s.bits + lanes;
            if (s.bits + lanes == 4'h8)
            begin
                next_s.ph     = PH_IGN;
                next_s.rst_en = 1'b0; // [RQ20]
                next_s.idx    = 8'h00;
                next_s.ok     = 1'b1;
                case (op)
                    fid_pkg::OP_CLEAR_ERR: next_s.errs = err_set; // [RQ1]
                    fid_pkg::OP_NO_OP:     next_s.rst_en = 1'b0; // [RQ20]
                    fid_pkg::OP_RST_EN:    next_s.rst_en = 1'b1;
                    fid_pkg::OP_SIG_READ:
                        if (write_in_progress_flag)
                        begin
                            next_s.rst_en = s.rst_en; // [RQ22]
                        end
                        else
                        begin
                            next_s.wake     = 1'b1; // [RQ6]
                            next_s.kind     = fid_pkg::RESP_SIG;
                            next_s.ph       = PH_ADDR;
                            next_s.clk_left = aclk; // [RQ3]
                            next_s.dum      = 6'h0;
                        end
                    fid_pkg::OP_STD_ID:
                    begin
                        next_s.kind = fid_pkg::RESP_STD;
                        next_s.ph   = PH_OUT; // [RQ7]
                    end
                    fid_pkg::OP_STD_ID_Q:
                        if (quad_command_mode)
                        begin
                            next_s.kind = fid_pkg::RESP_STD;
                            next_s.ph   = PH_OUT; // [RQ7]
                        end
                    fid_pkg::OP_MD_READ:
                    begin
                        next_s.kind     = fid_pkg::RESP_MD;
                        next_s.ph       = PH_ADDR;
                        next_s.clk_left = aclk; // [RQ10]
                        next_s.dum      = 6'h0;
                    end
                    fid_pkg::OP_UID_READ, fid_pkg::OP_PAR_READ:
                    begin
                        next_s.kind     = (op == fid_pkg::OP_UID_READ) ? fid_pkg::RESP_UID
                                                                       : fid_pkg::RESP_PAR;
                        next_s.ph       = PH_ADDR;
                        next_s.clk_left = aclk + dcnt; // [RQ13] [RQ16] [RQ17] [RQ19]
                        next_s.dum      = dcnt;
                    end
                    default: next_s.ph = PH_IGN;
                endcase
            end
        end
        else if (rise && s.ph == PH_ADDR)
        begin
            // Dummy clocks must not disturb the captured address
            if (s.clk_left > s.dum)
            begin
                next_s.addr = na;
            end
            next_s.clk_left = s.clk_left - 6'h1;
            if (s.clk_left == 6'h1)
            begin
                next_s.ph = PH_OUT;
                case (s.kind)
                    fid_pkg::RESP_MD:  next_s.idx = {7'h0, next_s.addr[0]}; // [RQ11]
                    fid_pkg::RESP_UID:
                    begin
                        next_s.idx = {4'h0, next_s.addr[3:0]};
                        next_s.ok  = (next_s.addr[8:4] == 5'h00); // [RQ15]
                    end
                    fid_pkg::RESP_PAR:
                    begin
                        next_s.idx = next_s.addr[7:0];
                        next_s.ok  = (next_s.addr[23:8] == 16'h0000); // [RQ18]
                    end
                    default: next_s.idx = 8'h00;
                endcase
            end
        end
        else if (fall && s.ph == PH_OUT)
        begin
            if (quad_command_mode)
            begin
                next_s.dout = (s.bpos == 4'h0) ? rom_byte[7:4] : rom_byte[3:0];
                next_s.doe  = 4'hf;
            end
            else
            begin
                next_s.dout = {2'h0, rom_byte[3'(4'h7 - s.bpos)], 1'b0}; // [RQ4]
                next_s.doe  = 4'h2;
            end
            next_s.bpos = s.bpos + lanes;
            if (s.bpos + lanes == 4'h8)
            begin
                next_s.bpos = 4'h0;
                case (s.kind)
                    fid_pkg::RESP_SIG: next_s.idx = 8'h00; // [RQ5]
                    fid_pkg::RESP_STD:
                        next_s.idx = (s.idx == fid_pkg::STD_ID_LAST) ? 8'h00
                                                                     : s.idx + 8'h1; // [RQ8] [RQ9]
                    // Byte counter wraps: bit 0 alternates, low nibble cycles 16
                    default: next_s.idx = s.idx + 8'h1; // [RQ12] [RQ14]
                endcase
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            s          <= '0;
            s.cs_s1    <= 1'b1;
            s.cs_s2    <= 1'b1;
            s.ph       <= PH_CMD;
            s.kind     <= fid_pkg::RESP_SIG;
            s.errs     <= fid_pkg::ERR_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign link.dev_io          = s.dout;
    assign link.dev_oe          = s.doe;
    assign error_flags          = s.errs;
    assign reset_enable_pending = s.rst_en;
    assign power_down_release   = s.wake;
endmodule

/* File: fid_host.sv */
// Flash controller end: issues one command frame and collects read bytes
`timescale 1ns/100ps
module fid_host (
    input  wire logic        mclk,
    input  wire logic        resetn,
    fid_link_if.host         link,
    input  wire logic        start,
    input  wire logic        quad,
    input  wire logic [7:0]  opcode,
    input  wire logic [23:0] addr,
    input  wire logic [1:0]  addr_bytes,
    input  wire logic [4:0]  dummy_clks,
    input  wire logic [7:0]  rd_bytes,
    output logic             busy,
    output logic             done,
    output logic [7:0]       rx_data,
    output logic             rx_valid
);
    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {
        H_IDLE,
        H_TX,
        H_DUM,
        H_RX,
        H_GAP
    } fid_host_st_t;

    typedef struct packed {
        fid_host_st_t st;
        logic [3:0]   io_s1;
        logic [3:0]   io_s2;
        logic         q;
        logic [3:0]   div;
        logic         sck;
        logic         cs_n;
        logic [31:0]  txsr;
        logic [5:0]   txclk;
        logic [4:0]   dum;
        logic [7:0]   rdn;
        logic [7:0]   rxsr;
        logic [3:0]   rxbit;
        logic [3:0]   io_o;
        logic [3:0]   io_oe;
        logic [7:0]   rx_data;
        logic         rx_valid;
        logic         done;
        logic         busy;
    } fid_host_state_t;

    fid_host_state_t s;
    fid_host_state_t next_s;

    always_comb
    begin
        logic [3:0]  lanes;
        logic [31:0] sh;
        logic [7:0]  rb;
        lanes = s.q ? 4'h4 : 4'h1;
        sh    = s.q ? {s.txsr[27:0], 4'h0} : {s.txsr[30:0], 1'b0};
        rb    = s.q ? {s.rxsr[3:0], s.io_s2} : {s.rxsr[6:0], s.io_s2[1]};

        next_s          = s;
        next_s.io_s1    = link.io;
        next_s.io_s2    = s.io_s1;
        next_s.rx_valid = 1'b0;
        next_s.done     = 1'b0;

        case (s.st)
            H_IDLE:
                if (start)
                begin
                    next_s.st    = H_TX;
                    next_s.q     = quad;
                    next_s.busy  = 1'b1;
                    next_s.cs_n  = 1'b0; // [RQ23]
                    next_s.div   = 4'h0;
                    next_s.txsr  = {opcode, addr};
                    next_s.txclk = quad ? 6'h02 + {3'h0, addr_bytes, 1'b0}
                                        : 6'h08 + {1'b0, addr_bytes, 3'h0}; // [RQ3] [RQ10]
                    next_s.dum   = dummy_clks; // [RQ13] [RQ17]
                    next_s.rdn   = rd_bytes;
                    next_s.rxbit = 4'h0;
                    next_s.io_o  = quad ? opcode[7:4] : {3'h0, opcode[7]};
                    next_s.io_oe = quad ? 4'hf : 4'h1;
                end
            H_GAP:
            begin
                // Keeps select high long enough for the far end to see it
                next_s.div = s.div + 4'h1;
                if (s.div == fid_pkg::SCK_HALF_CYC - 4'h1)
                begin
                    next_s.st   = H_IDLE;
                    next_s.busy = 1'b0;
                    next_s.done = 1'b1;
                end
            end
            default:
            begin
                next_s.div = s.div + 4'h1;
                if (s.div == fid_pkg::SCK_HALF_CYC - 4'h1)
                begin
                    next_s.div = 4'h0;
                    next_s.sck = ~s.sck;
                    if (!s.sck)
                    begin
                        // Rising edge: sample returned data
                        if (s.st == H_RX)
                        begin
                            next_s.rxsr  = rb;
                            next_s.rxbit = s.rxbit + lanes;
                            if (s.rxbit + lanes == 4'h8)
                            begin
                                next_s.rxbit    = 4'h0;
                                next_s.rx_data  = rb;
                                next_s.rx_valid = 1'b1;
                                next_s.rdn      = s.rdn - 8'h1;
                            end
                        end
                    end
                    else
                    begin
                        // Falling edge: advance the frame
                        case (s.st)
                            H_TX:
                                if (s.txclk == 6'h1)
                                begin
                                    next_s.io_oe = 4'h0;
                                    next_s.st    = (s.dum != 5'h0) ? H_DUM :
                                                   (s.rdn != 8'h0) ? H_RX : H_GAP;
                                end
                                else
                                begin
                                    next_s.txclk = s.txclk - 6'h1;
                                    next_s.txsr  = sh;
                                    next_s.io_o  = s.q ? sh[31:28] : {3'h0, sh[31]};
                                end
                            H_DUM:
                                if (s.dum == 5'h1)
                                begin
                                    next_s.st = (s.rdn != 8'h0) ? H_RX : H_GAP;
                                end
                                else
                                begin
                                    next_s.dum = s.dum - 5'h1;
                                end
                            H_RX:
                                if (s.rdn == 8'h0)
                                begin
                                    next_s.st = H_GAP; // [RQ17]
                                end
                            default: next_s.st = H_GAP;
                        endcase
                        if (next_s.st == H_GAP)
                        begin
                            next_s.cs_n = 1'b1;
                            next_s.div  = 4'h0;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            s      <= '0;
            s.st   <= H_IDLE;
            s.cs_n <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign link.cs_n    = s.cs_n;
    assign link.sck     = s.sck;
    assign link.host_io = s.io_o;
    assign link.host_oe = s.io_oe;
    assign busy         = s.busy;
    assign done         = s.done;
    assign rx_data      = s.rx_data;
    assign rx_valid     = s.rx_valid;
endmodule

/* File: fid_link_if.sv */
// Serial link between flash controller and flash device
`timescale 1ns/100ps
interface fid_link_if;
    logic       cs_n;
    logic       sck;
    logic [3:0] host_io;
    logic [3:0] host_oe;
    logic [3:0] dev_io;
    logic [3:0] dev_oe;
    logic [3:0] io;

    // Weak pull-up when nobody drives a lane
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        assign io[g] = host_oe[g] ? host_io[g] : (dev_oe[g] ? dev_io[g] : 1'b1);
    end

    modport host (output cs_n, output sck, output host_io, output host_oe, input io);
    modport dev  (input cs_n, input sck, input io, output dev_io, output dev_oe);
endinterface

/* File: fid_link_monitor.sv */
// Protocol checker watching the serial link between both ends
`timescale 1ns/100ps
module fid_link_monitor (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic [3:0] host_io,
    input wire logic [3:0] host_oe,
    input wire logic [3:0] dev_io,
    input wire logic [3:0] dev_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_desel; cs_n [*4]; endsequence
    sequence s_live; !cs_n && dev_oe != 4'h0; endsequence
    property p_idle_oe; s_desel |-> dev_oe == 4'h0; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("device drives while idle");
    property p_one_drv; (host_oe & dev_oe) == 4'h0; endproperty
    a_one_drv: assert property (p_one_drv) else $error("lane contention");
    property p_dout_fall; $changed(dev_io) |-> !sck; endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("data moved with clock high");
    property p_hin; !cs_n && sck && host_oe != 4'h0 |-> $stable(host_io); endproperty
    a_hin: assert property (p_hin) else $error("host data moved with clock high");
    property p_sck_idle; cs_n |-> !sck; endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock runs while idle");
    property p_hold; s_live |=> dev_oe != 4'h0; endproperty
    a_hold: assert property (p_hold) else $error("output stopped while selected");
    property p_drop; $rose(cs_n) |-> ##[1:4] dev_oe == 4'h0; endproperty
    a_drop: assert property (p_drop) else $error("output kept after deselect");
    property p_oe_rise; $rose(dev_oe != 4'h0) |-> !sck; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("output began on clock high");
endmodule

/* File: fid_pkg.sv */
// Shared constants and types for the flash identification command block
package fid_pkg;

    // ************************************************************
    // Instruction codes
    // ************************************************************
    localparam logic [7:0] OP_CLEAR_ERR = 8'h82;
    localparam logic [7:0] OP_SIG_READ  = 8'hab;
    localparam logic [7:0] OP_STD_ID    = 8'h9f;
    localparam logic [7:0] OP_STD_ID_Q  = 8'haf;
    localparam logic [7:0] OP_MD_READ   = 8'h90;
    localparam logic [7:0] OP_UID_READ  = 8'h4b;
    localparam logic [7:0] OP_PAR_READ  = 8'h5a;
    localparam logic [7:0] OP_NO_OP     = 8'h00;
    localparam logic [7:0] OP_RST_EN    = 8'h66;

    // ************************************************************
    // Identity values (all arbitrary)
    // ************************************************************
    localparam logic [7:0]  MAKER_CODE  = 8'h5e;
    localparam logic [7:0]  DEVICE_CODE = 8'h3c;
    localparam logic [15:0] TYPE_CAP    = 16'h4218;
    localparam logic [7:0]  UID_SEED    = 8'ha7;

    // ************************************************************
    // Framing and sizes
    // ************************************************************
    localparam logic [5:0] ADDR_CLK_SGL = 6'h18;
    localparam logic [5:0] ADDR_CLK_QD  = 6'h06;
    localparam logic [5:0] DUMMY_DEF    = 6'h08;
    localparam logic [7:0] STD_ID_LAST  = 8'h02;
    localparam int         UID_LEN      = 16;
    localparam int         PAR_LEN      = 16;
    localparam logic [7:0] UNDEF_BYTE   = 8'hff;
    localparam logic [2:0] ERR_RESET    = 3'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         MCLK_PS      = 5000;
    localparam int         SCK_HALF_NS  = 40;
    localparam logic [3:0] SCK_HALF_CYC = 4'((SCK_HALF_NS * 1000 + MCLK_PS - 1) / MCLK_PS);

    typedef enum logic [2:0] {
        RESP_SIG,
        RESP_STD,
        RESP_MD,
        RESP_UID,
        RESP_PAR
    } fid_resp_t;

endpackage

/* File: fid_resp_rom.sv */
// Response byte source for identification and table reads
`timescale 1ns/100ps
module fid_resp_rom (
    input  wire fid_pkg::fid_resp_t kind,
    input  wire logic [7:0]         idx,
    input  wire logic               addr_ok,
    output logic [7:0]              data
);
    logic [7:0] uid [fid_pkg::UID_LEN];
    logic [7:0] par [fid_pkg::PAR_LEN];

    // Factory number: fixed pattern per entry
    for (genvar g = 0; g < fid_pkg::UID_LEN; g++)
    begin : g_uid
        assign uid[g] = fid_pkg::UID_SEED ^ 8'(g * 37);
    end

    // Parameter table: signature then revision, rest blank
    for (genvar g = 0; g < fid_pkg::PAR_LEN; g++)
    begin : g_par
        assign par[g] = (g == 0) ? 8'h53 : (g == 1) ? 8'h46 : (g == 2) ? 8'h44 :
                        (g == 3) ? 8'h50 : (g == 4) ? 8'h06 : (g == 5) ? 8'h01 :
                        fid_pkg::UNDEF_BYTE;
    end

    always_comb
    begin
        case (kind)
            fid_pkg::RESP_SIG: data = fid_pkg::DEVICE_CODE;
            fid_pkg::RESP_STD:
                data = (idx == 8'h00) ? fid_pkg::MAKER_CODE :
                       (idx == 8'h01) ? fid_pkg::TYPE_CAP[15:8] : fid_pkg::TYPE_CAP[7:0];
            fid_pkg::RESP_MD:  data = idx[0] ? fid_pkg::DEVICE_CODE : fid_pkg::MAKER_CODE;
            fid_pkg::RESP_UID: data = addr_ok ? uid[idx[3:0]] : fid_pkg::UNDEF_BYTE;
            fid_pkg::RESP_PAR:
                // Outside the table the value is not guaranteed
                data = (addr_ok && idx < 8'(fid_pkg::PAR_LEN)) ? par[idx[3:0]]
                                                                : fid_pkg::UNDEF_BYTE;
            default:           data = fid_pkg::UNDEF_BYTE;
        endcase
    end
endmodule

/* File: tb_flash_ident_query_commands.sv */
// Self-checking bench joining the controller end to the device end
`timescale 1ns/100ps
module tb_flash_ident_query_commands;
    logic        mclk, resetn, start, quad, qm, wbusy, busy, done, rxv, pdr, rep;
    logic [2:0]  es, ef;
    logic [3:0]  rdc;
    logic [4:0]  dm;
    logic [1:0]  ab;
    logic [7:0]  op, n, rx;
    logic [23:0] ad;
    logic [7:0]  got [0:31];
    int          miscompares = 0, compares = 0, pdr_cnt = 0, i, j;

    fid_link_if link ();
    fid_host fid_host_i (.mclk, .resetn, .link(link.host), .start, .quad, .opcode(op),
        .addr(ad), .addr_bytes(ab), .dummy_clks(dm), .rd_bytes(n), .busy, .done,
        .rx_data(rx), .rx_valid(rxv));
    fid_device fid_device_i (.mclk, .resetn, .link(link.dev), .quad_command_mode(qm),
        .write_in_progress_flag(wbusy), .read_dummy_cycles(rdc), .protection_error_set(es[2]),
        .program_error_set(es[1]), .erase_error_set(es[0]), .error_flags(ef),
        .reset_enable_pending(rep), .power_down_release(pdr));
    fid_link_monitor fid_link_monitor_i (.mclk, .resetn, .cs_n(link.cs_n), .sck(link.sck),
        .host_io(link.host_io), .host_oe(link.host_oe), .dev_io(link.dev_io),
        .dev_oe(link.dev_oe));

    initial
    begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (pdr === 1'b1)
            pdr_cnt++;

    function automatic logic [7:0] uid(input int k);
        return fid_pkg::UID_SEED ^ 8'((k % 16) * 37);
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One whole frame; bytes are caught at the falling edge, where rx_valid has settled
    task automatic run(input logic [7:0] o, input int a, input int b, input int d, input int k);
        int w, c;
        @(negedge mclk);
        {op, ad, ab, dm, n, quad, start} = {o, 24'(a), 2'(b), 5'(d), 8'(k), qm, 1'b1};
        @(negedge mclk);
        start = 0;
        chk({7'h0, busy}, 8'h01);
        c = 0;
        for (w = 0; w < 8000 && done !== 1'b1; w++)
        begin
            @(negedge mclk);
            if (rxv === 1'b1)
                got[c++] = rx;
        end
        if (done !== 1'b1)
        begin
            miscompares++;
            close_out();
        end
    endtask

    initial
    begin
        {resetn, start, quad, qm, wbusy, es, rdc, op, ad, ab, dm, n} = '0;
        repeat (3) @(negedge mclk);
        resetn = 1;
        for (i = 0; i < 4; i++)
        begin
            qm = (i == 1 || i == 2);
            run(i > 1 ? fid_pkg::OP_STD_ID_Q : fid_pkg::OP_STD_ID, 0, 0, 0, 6);
            for (j = 0; j < 6; j++)
                chk(got[j], i == 3 ? 8'hff : 8'({fid_pkg::MAKER_CODE, fid_pkg::TYPE_CAP} >> (16 - 8 * (j % 3))));
        end
        for (i = 0; i < 3; i++)
        begin
            qm = (i == 2);
            wbusy = (i == 1);
            run(fid_pkg::OP_SIG_READ, 0, 3, 0, 3);
            for (j = 0; j < 3; j++)
                chk(got[j], wbusy ? 8'hff : fid_pkg::DEVICE_CODE);
        end
        chk(8'(pdr_cnt), 8'h02);
        {wbusy, qm} = 2'b00;
        for (i = 0; i < 2; i++)
        begin
            run(fid_pkg::OP_MD_READ, 24'(i), 3, 0, 4);
            for (j = 0; j < 4; j++)
                chk(got[j], ((i + j) % 2) ? fid_pkg::DEVICE_CODE : fid_pkg::MAKER_CODE);
        end
        // Quad pass also moves the dummy count away from its default
        for (i = 0; i < 3; i++)
        begin
            qm = (i == 2);
            rdc = (i == 2) ? 4'h4 : 4'h0;
            run(fid_pkg::OP_UID_READ, i == 1 ? 24'h000010 : 24'hab0005, 3, i == 2 ? 5'h04 : 5'h08, 17);
            for (j = 0; j < 17; j++)
                chk(got[j], i == 1 ? 8'hff : uid(5 + j));
        end
        rdc = 4'h0;
        for (i = 0; i < 2; i++)
        begin
            qm = (i == 1);
            run(fid_pkg::OP_PAR_READ, 0, 3, 8, 7);
            for (j = 0; j < 7; j++)
                chk(got[j], 8'(56'h534644500601ff >> (48 - 8 * j)));
        end
        qm = 0;
        @(negedge mclk);
        es = 3'h7;
        @(negedge mclk);
        es = 3'h0;
        run(fid_pkg::OP_STD_ID, 0, 0, 0, 1);
        run(fid_pkg::OP_RST_EN, 0, 0, 0, 0);
        chk({4'h0, rep, ef}, 8'h0f);
        run(fid_pkg::OP_NO_OP, 0, 0, 0, 0);
        chk({4'h0, rep, ef}, 8'h07);
        run(fid_pkg::OP_CLEAR_ERR, 0, 0, 0, 0);
        chk({5'h0, ef}, 8'h00);
        close_out();
    end
endmodule
